//--- hdl/pattern_defines.svh
// Constants of the multi-channel pattern generator: offsets, fields, resets and counts
// Overview of operation
// - Seventh-order generator uses taps x^6 and x^7, period 2^7-1.
// - Tenth-order generator uses taps x^7 and x^10.
// - Eleventh-order generator uses taps x^9 and x^11.
// - Thirteenth-order generator uses taps x, x^2, x^12 and x^13.
// - Fifteenth-order generator uses taps x^14 and x^15.
// - Twentieth-order generator uses taps x^3 and x^20.
// - Twenty-third-order generator uses taps x^18 and x^23.
// - Eight generation lanes, stepped by one common enable that is halved for channels with the divider on.
// - Each output merges two lanes two-to-one into one double-rate stream.
// - Full-clock mode halves the incoming rate; half-clock mode uses it directly.
// - Main clock output runs at the incoming rate.
// - Half-rate clock output runs at exactly half the incoming rate.
// - Selectable clock output is incoming rate divided by 2..128, powers of two.
// - Each channel replays a loaded user pattern from its own memory repeatedly.
// - User pattern length counts in 256-bit words; software pads to that.
// - Bit rate divider allows rates below the normal minimum.
// - With divider on, every PRBS bit is sent twice in a row; user bits follow the divider of channel 1 (pair 1&3) or 2 (pair 2&4).
// - Per-channel polarity bit inverts every output bit.
// - PRBS start offset settable per channel in single-bit steps.
// - Channels 1&3 and 2&4 share a memory controller and one pattern length.
`ifndef PATTERN_DEFINES_SVH
`define PATTERN_DEFINES_SVH
// Register byte offsets
`define OFS_CLOCK_CTRL   12'h000
`define OFS_STATUS       12'h004
`define OFS_MEM_ADDR     12'h008
`define OFS_MEM_DATA     12'h00c
`define OFS_LEN_A        12'h010
`define OFS_LEN_B        12'h014
`define OFS_CHAN_BASE    12'h020
`define OFS_SHIFT_BASE   12'h040
// Clock control fields
`define CLK_FULL_BIT     0
`define CLK_RUN_BIT      1
`define CLK_SEL_LSB      4
`define CLK_SEL_W        3
// Channel control fields
`define CH_PAT_LSB       0
`define CH_PAT_W         4
`define CH_USER_BIT      4
`define CH_INV_BIT       5
`define CH_DIV2_BIT      6
// Memory geometry: 256-bit words, 32-bit bus slices
`define MEM_WORD_W       256
`define MEM_DEPTH        16
`define MEM_AW           4
`define SLICE_AW         3
// Reset values
`define RST_CLOCK_CTRL   32'h0000_0000
`define RST_CHAN         32'h0000_0000
`define RST_SEED         31'h7fff_ffff
`endif

//--- hdl/pattern_pkg.sv
// Types shared by the pattern generator modules
package pattern_pkg;
  typedef enum logic [3:0] {
    prbs7 = 4'h0, prbs9 = 4'h1, prbs10 = 4'h2, prbs11 = 4'h3, prbs13 = 4'h4,
    prbs15 = 4'h5, prbs20 = 4'h6, prbs23 = 4'h7, prbs31 = 4'h8
  } prbs_sel_t;
  typedef enum logic [2:0] {
    ld_idle = 3'b001, ld_skip = 3'b010, ld_run = 3'b100
  } lane_state_t;
endpackage

//--- hdl/prbs_lane.sv
// One pseudo-random generation lane with selectable polynomial and start offset
`timescale 1ns/1ps
`default_nettype none
`include "pattern_defines.svh"
module prbs_lane
  import pattern_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Control
  input  wire logic        step,
  input  wire logic        restart,
  input  wire logic [3:0]  sel,
  input  wire logic [30:0] skip,
  // Stream
  output logic             bit_out
);
  typedef struct packed {
    lane_state_t st;
    logic [30:0] lfsr;
    logic [30:0] cnt;
  } lane_s_t;
  lane_s_t s, next_s;

  // Feedback for each polynomial
  function automatic logic fb(input logic [30:0] r, input logic [3:0] p);
    case (p)
      4'h0:    fb = r[6] ^ r[5];
      4'h1:    fb = r[8] ^ r[4];
      4'h2:    fb = r[9] ^ r[6];
      4'h3:    fb = r[10] ^ r[8];
      4'h4:    fb = r[12] ^ r[11] ^ r[1] ^ r[0];
      4'h5:    fb = r[14] ^ r[13];
      4'h6:    fb = r[19] ^ r[2];
      4'h7:    fb = r[22] ^ r[17];
      default: fb = r[30] ^ r[27];
    endcase
  endfunction

  // Skip steps the register without output so lanes start offset
  always_comb begin
    next_s = s;
    case (s.st)
      ld_idle: begin
        next_s.st = (skip == 31'h0) ? ld_run : ld_skip;
        next_s.cnt = skip;
      end
      ld_skip: begin
        next_s.lfsr = {s.lfsr[29:0], fb(s.lfsr, sel)};
        next_s.cnt = s.cnt - 31'h1;
        if (s.cnt == 31'h1) begin
          next_s.st = ld_run;
        end
      end
      ld_run: begin
        // Half-rate lane: each step moves two positions, its partner fills the odd slots
        if (step) begin
          next_s.lfsr = {s.lfsr[29:0], fb(s.lfsr, sel)};
          next_s.lfsr = {next_s.lfsr[29:0], fb(next_s.lfsr, sel)};
        end
      end
      default: next_s.st = ld_idle;
    endcase
    if (restart) begin
      next_s.st = ld_idle;
      next_s.lfsr = `RST_SEED;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{st: ld_idle, lfsr: `RST_SEED, cnt: 31'h0};
    end else begin
      s <= next_s;
    end
  end

  assign bit_out = s.lfsr[30];
endmodule // prbs_lane
`default_nettype wire

//--- hdl/clock_section.sv
// Clock distribution: half-rate enable, main, half and selectable clock outputs
`timescale 1ns/1ps
`default_nettype none
`include "pattern_defines.svh"
module clock_section
  import pattern_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control
  input  wire logic       full_mode,
  input  wire logic [2:0] div_sel,
  // Outputs
  output logic            gen_en,
  output logic            clk_main,
  output logic            clk_half,
  output logic            clk_sel
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       main;
  } clk_s_t;
  clk_s_t s, next_s;

  // Free-running count; bit k toggles at input/2^(k+1)
  always_comb begin
    next_s = s;
    next_s.cnt = s.cnt + 8'h1;
    next_s.main = ~s.main;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign gen_en = full_mode ? s.cnt[0] : 1'b1;
  assign clk_main = s.main;
  assign clk_half = s.cnt[1];
  // Code n gives the main rate over 2^(n+1); unused code 7 wraps to the fastest bit
  assign clk_sel = s.cnt[div_sel + 3'h1];
endmodule // clock_section
`default_nettype wire

//--- hdl/pattern_generator.sv
// Multi-channel pattern generator top with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "pattern_defines.svh"
module pattern_generator
  import pattern_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial outputs and clocks
  output logic [3:0]       data_out,
  output logic             clk_out,
  output logic             clk_half_out,
  output logic             clk_sel_out
);
  localparam int NCH = 4;

  typedef struct packed {
    logic        wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic [31:0] clk_ctrl;
    logic [NCH-1:0][7:0] chan;
    logic [NCH-1:0][30:0] shift;
    logic [`MEM_AW+`SLICE_AW-1:0] mem_addr;
    logic [1:0][`MEM_AW-1:0] len;
    logic [1:0][`MEM_AW-1:0] rd_ptr;
    logic [1:0][7:0] bit_pos;
    logic        phase;
    logic        rep;
    logic        restart;
    logic [31:0] hold;
    logic [3:0]  dout;
  } top_s_t;
  top_s_t s, next_s;

  // Per-channel user memory, 256-bit words
  logic [`MEM_WORD_W-1:0] mem [NCH][`MEM_DEPTH];
  logic [`MEM_WORD_W-1:0] word_a [NCH];

  logic       gen_en;
  logic [7:0] lane_bit;
  logic       bus_req;
  logic       step;

  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] base,
                                   input int n);
    reg_hit = (a >= base) && (a < base + 12'(4 * n));
  endfunction

  // Cycles until every lane has skipped to its start offset after a restart
  function automatic logic [31:0] settle(input logic [NCH-1:0][30:0] sh);
    settle = 32'h2;
    for (int c = 0; c < NCH; c++) begin
      if (32'(sh[c]) + 32'h2 > settle) settle = 32'(sh[c]) + 32'h2;
    end
  endfunction

  // Clock section
  clock_section u_clk (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .full_mode (s.clk_ctrl[`CLK_FULL_BIT]),
    .div_sel   (s.clk_ctrl[`CLK_SEL_LSB +: `CLK_SEL_W]),
    .gen_en    (gen_en),
    .clk_main  (clk_out),
    .clk_half  (clk_half_out),
    .clk_sel   (clk_sel_out)
  );

  // Slots wait for all lanes to finish skipping, else a lane pair would lose its alignment
  assign step = gen_en && s.clk_ctrl[`CLK_RUN_BIT] && (s.hold == 32'h0);

  // Eight lanes on one enable, gated per channel by the divider; two per channel
  generate
    for (genvar g = 0; g < 2 * NCH; g++) begin : g_lane
      logic lane_step;
      assign lane_step = step && s.phase && !(s.chan[g/2][`CH_DIV2_BIT] && !s.rep);
      prbs_lane u_lane (
        .hclk    (hclk),
        .hresetn (hresetn),
        .step    (lane_step),
        .restart (s.restart),
        .sel     (s.chan[g/2][`CH_PAT_LSB +: `CH_PAT_W]),
        .skip    (s.shift[g/2] + 31'(g % 2)),
        .bit_out (lane_bit[g])
      );
    end
  endgenerate

  // Memory writes from the bus, one 32-bit slice at a time
  always_ff @(posedge hclk) begin
    if (s.wr_pend && s.wr_addr == `OFS_MEM_DATA) begin
      for (int c = 0; c < NCH; c++) begin
        mem[c][s.mem_addr[`MEM_AW+`SLICE_AW-1:`SLICE_AW]][32*s.mem_addr[`SLICE_AW-1:0] +: 32]
          <= hwdata;
      end
    end
  end

  // Read ports of the shared controllers (1&3 use A, 2&4 use B)
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      word_a[c] = mem[c][s.rd_ptr[c % 2]];
    end
  end

  assign bus_req = hsel && hready && htrans[1];

  // Next-state logic: bus, user replay, output merge
  always_comb begin
    next_s = s;
    next_s.restart = 1'b0;
    next_s.wr_pend = bus_req && hwrite;
    next_s.wr_addr = haddr;
    if (bus_req && !hwrite) begin
      next_s.rdata = 32'h0;
      case (haddr)
        `OFS_CLOCK_CTRL: next_s.rdata = s.clk_ctrl;
        `OFS_STATUS:     next_s.rdata = {24'h0, lane_bit};
        `OFS_MEM_ADDR:   next_s.rdata = 32'(s.mem_addr);
        `OFS_LEN_A:      next_s.rdata = 32'(s.len[0]);
        `OFS_LEN_B:      next_s.rdata = 32'(s.len[1]);
        default: begin
          for (int c = 0; c < NCH; c++) begin
            if (haddr == `OFS_CHAN_BASE + 12'(4 * c)) next_s.rdata = 32'(s.chan[c]);
            if (haddr == `OFS_SHIFT_BASE + 12'(4 * c)) next_s.rdata = 32'(s.shift[c]);
          end
        end
      endcase
    end
    if (s.wr_pend) begin
      case (s.wr_addr)
        `OFS_CLOCK_CTRL: begin
          next_s.clk_ctrl = hwdata;
          next_s.restart = 1'b1;
        end
        `OFS_MEM_ADDR:   next_s.mem_addr = hwdata[`MEM_AW+`SLICE_AW-1:0];
        `OFS_MEM_DATA:   next_s.mem_addr = s.mem_addr + 7'h1;
        `OFS_LEN_A:      next_s.len[0] = hwdata[`MEM_AW-1:0];
        `OFS_LEN_B:      next_s.len[1] = hwdata[`MEM_AW-1:0];
        default: begin
          for (int c = 0; c < NCH; c++) begin
            if (reg_hit(s.wr_addr, `OFS_CHAN_BASE, NCH) && s.wr_addr[3:2] == 2'(c)) begin
              next_s.chan[c] = hwdata[7:0];
              next_s.restart = 1'b1;
            end
            if (reg_hit(s.wr_addr, `OFS_SHIFT_BASE, NCH) && s.wr_addr[3:2] == 2'(c)) begin
              next_s.shift[c] = hwdata[30:0];
              next_s.restart = 1'b1;
            end
          end
        end
      endcase
    end
    // Output slot sequencing
    if (step) begin
      next_s.phase = ~s.phase;
      if (s.phase) begin
        next_s.rep = ~s.rep;
      end
      for (int k = 0; k < 2; k++) begin
        if (s.phase || !s.chan[k][`CH_DIV2_BIT]) begin
          next_s.bit_pos[k] = s.bit_pos[k] + 8'h1;
          if (s.bit_pos[k] == 8'hff) begin
            next_s.rd_ptr[k] = (s.rd_ptr[k] == s.len[k]) ? '0 : s.rd_ptr[k] + 4'h1;
          end
        end
      end
      // Two lanes interleaved into one stream per channel
      for (int c = 0; c < NCH; c++) begin
        // With the divider one lane feeds a whole slot pair, so each bit goes out twice
        next_s.dout[c] = s.chan[c][`CH_USER_BIT] ?
                         word_a[c][s.bit_pos[c % 2]] :
                         lane_bit[2 * c + 32'(s.chan[c][`CH_DIV2_BIT] ?
                                              s.rep : s.phase)];
        next_s.dout[c] = next_s.dout[c] ^ s.chan[c][`CH_INV_BIT];
      end
    end
    if (s.hold != 32'h0) begin
      next_s.hold = s.hold - 32'h1;
    end
    if (s.restart) begin
      next_s.phase = 1'b0;
      next_s.rep = 1'b0;
      next_s.rd_ptr = '0;
      next_s.bit_pos = '0;
      next_s.hold = settle(s.shift);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign data_out = s.dout;
endmodule // pattern_generator
`default_nettype wire

//--- verif/pattern_checker.sv
// Port assertions for the pattern generator
`timescale 1ns/1ps
`default_nettype none
module pattern_checker (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Streams and clocks
  input wire logic [3:0]  data_out,
  input wire logic        clk_out,
  input wire logic        clk_half_out,
  input wire logic        clk_sel_out
);
  logic        wr_ph;
  logic        ctl_ph;
  logic [7:0]  age;
  logic [7:0]  gap;
  logic [31:0] cfg;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Clock control shadow; age masks the restart that follows any write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph  <= 1'b0;
      ctl_ph <= 1'b0;
      age    <= 8'h00;
      gap    <= 8'h00;
      cfg    <= 32'h0000_0000;
    end else begin
      wr_ph  <= hsel && hready && htrans[1] && hwrite;
      ctl_ph <= hsel && hready && htrans[1] && hwrite && haddr == 12'h000;
      cfg    <= ctl_ph ? hwdata : cfg;
      age    <= wr_ph ? 8'h00 : age + 8'(age != 8'hff);
      gap    <= $changed(clk_sel_out) ? 8'h00 : gap + 8'h01;
    end
  end
  a_main_toggle: assert property ($past(hresetn) |-> clk_out != $past(clk_out))
    else $error("main clock missed a toggle");
  a_half_rate: assert property ($past(hresetn) && $changed(clk_half_out)
    |=> $stable(clk_half_out) ##1 $changed(clk_half_out)) else $error("half clock rate wrong");
  a_sel_ratio: assert property (age == 8'hff && $changed(clk_sel_out)
    |-> gap == (8'h02 << cfg[6:4]) - 8'h01) else $error("selectable clock ratio wrong");
  a_full_pairs: assert property (age == 8'hff && cfg[1] && cfg[0] && $changed(data_out)
    |=> $stable(data_out)) else $error("full mode stepped twice in a row");
  a_stop_quiet: assert property (age == 8'hff && !cfg[1] |-> $stable(data_out))
    else $error("lanes stepped while stopped");
  a_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite
    && haddr == 12'h100 |=> hrdata == 32'h0) else $error("unmapped read not zero");
  a_ready_high: assert property (hreadyout) else $error("wait state inserted");
  a_resp_okay: assert property (!hresp) else $error("error response seen");
endmodule // pattern_checker
bind pattern_generator pattern_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .data_out(data_out),
  .clk_out(clk_out), .clk_half_out(clk_half_out), .clk_sel_out(clk_sel_out));
`default_nettype wire

//--- verif/stream_sink.sv
// Receiving end: records the four streams and counts clock level changes
`timescale 1ns/1ps
`default_nettype none
module stream_sink (
  // Clock and capture start
  input wire logic       hclk,
  input wire logic       arm,
  // Streams and clocks from the generator
  input wire logic [3:0] data_out,
  input wire logic       clk_out,
  input wire logic       clk_half_out,
  input wire logic       clk_sel_out
);
  logic [3:0] bits [0:511];
  logic [2:0] prev;
  int         idx, n_main, n_half, n_sel;
  // One sample per clock cycle; a window holds 512 cycles
  always @(posedge hclk) begin
    prev <= {clk_out, clk_half_out, clk_sel_out};
    if (arm) begin
      idx <= 0;
      n_main <= 0;
      n_half <= 0;
      n_sel <= 0;
    end else if (idx < 512) begin
      bits[idx] <= data_out;
      idx <= idx + 1;
      n_main <= n_main + int'(prev[2] != clk_out);
      n_half <= n_half + int'(prev[1] != clk_half_out);
      n_sel <= n_sel + int'(prev[0] != clk_sel_out);
    end
  end
endmodule // stream_sink
`default_nettype wire

//--- verif/pattern_generator_tb.sv
// Self-checking bench for the pattern generator
`timescale 1ns/1ps
`default_nettype none
module pattern_generator_tb;
  import pattern_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, arm = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0, hrdata, rd_v;
  logic        hreadyout, hresp, clk_out, clk_half_out, clk_sel_out;
  logic [3:0]  data_out;
  int          fail_count = 0, tests_run = 0, cyc = 0, e;
  // Tap lags per pattern code: each new bit is the XOR of the bits this far back
  int lg [9][4] = '{'{6,7,0,0}, '{5,9,0,0}, '{7,10,0,0}, '{9,11,0,0},
    '{1,2,12,13}, '{14,15,0,0}, '{3,20,0,0}, '{18,23,0,0}, '{28,31,0,0}};
  always #2 hclk = ~hclk;
  pattern_generator dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .data_out(data_out),
    .clk_out(clk_out), .clk_half_out(clk_half_out), .clk_sel_out(clk_sel_out));
  stream_sink sink (.hclk(hclk), .arm(arm), .data_out(data_out), .clk_out(clk_out),
    .clk_half_out(clk_half_out), .clk_sel_out(clk_sel_out));
  // Single word transfer; read data taken at the data phase's closing edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_v = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Let the restart, the offset skip and the seed bits pass before recording
  task automatic cap();
    repeat (200) @(posedge hclk);
    @(posedge hclk) arm <= 1'b1;
    @(posedge hclk) arm <= 1'b0;
    repeat (514) @(posedge hclk);
  endtask
  // Recurrence violations of channel c, lags stretched by k, inversion inv
  function automatic int rec(int c, int p, int k, logic inv);
    int  bad;
    logic x;
    bad = 0;
    for (int n = 128; n < 512; n++) begin
      x = sink.bits[n][c] ^ inv ^ sink.bits[n-k*lg[p][0]][c] ^ sink.bits[n-k*lg[p][1]][c];
      if (lg[p][2] > 0) x = x ^ sink.bits[n-k*lg[p][2]][c] ^ sink.bits[n-k*lg[p][3]][c];
      bad += int'(x !== 1'b0);
    end
    return bad;
  endfunction
  // Stuck stream, or with pr set, bits not sent in equal pairs
  function automatic int shape(int c, logic pr);
    int ev, od, ones;
    ev = 0;
    od = 0;
    ones = 0;
    for (int n = 0; n < 510; n++) begin
      ones += int'(sink.bits[n][c] === 1'b1);
      if (n % 2 == 1) ev += int'(sink.bits[n][c] !== sink.bits[n+1][c]);
      else od += int'(sink.bits[n][c] !== sink.bits[n+1][c]);
    end
    return int'(ones == 0 || ones == 510) + int'(pr && ev != 0 && od != 0);
  endfunction
  function automatic int rep(int a, int b, int off);
    int m;
    m = 0;
    for (int n = 0; n < 256; n++) m += int'(sink.bits[n][a] !== sink.bits[n+off][b]);
    return m;
  endfunction
  function automatic int sh();
    for (int d = 1; d < 100; d++) if (rep(3, 0, d) == 0) return d;
    return 0;
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Hang guard: the whole sequence needs about 9100 cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (300) @(posedge hclk);
    bus(1'b0, 12'h100, 32'h0);
    chk(rd_v, 32'h0);
    $display("unmapped read done");
    for (int p = 0; p < 9; p++) begin
      bus(1'b1, 12'h04c, 32'(p + 1));
      bus(1'b1, 12'h020, 32'(p));
      bus(1'b1, 12'h024, 32'(p) | 32'h20);
      bus(1'b1, 12'h028, 32'(p) | 32'h40);
      bus(1'b1, 12'h02c, 32'(p));
      bus(1'b1, 12'h000, 32'h2 | 32'(p % 7) << 4);
      cap();
      e = 256 >> (p % 7);
      chk(32'(rec(0, p, 1, 1'b0)), 32'h0);
      chk(32'(shape(0, 1'b0)), 32'h0);
      chk(32'(rec(1, p, 1, 1'b1)), 32'h0);
      chk(32'(rec(2, p, 2, 1'b0) + shape(2, 1'b1)), 32'h0);
      chk(32'(sh()), 32'(p + 1));
      chk(32'(sink.n_main), 32'd512);
      chk(32'(sink.n_half >= 255 && sink.n_half <= 257), 32'h1);
      chk(32'(sink.n_sel >= e - 1 && sink.n_sel <= e + 1), 32'h1);
      $display("pattern %0d done", p);
    end
    bus(1'b1, 12'h000, 32'h3);
    cap();
    chk(32'(rec(0, 8, 2, 1'b0) + shape(0, 1'b1)), 32'h0);
    $display("full clock mode done");
    bus(1'b1, 12'h008, 32'h0);
    for (int i = 0; i < 8; i++) bus(1'b1, 12'h00c, 32'h9e37_79b9 * 32'(i + 1));
    bus(1'b1, 12'h010, 32'h0);
    bus(1'b1, 12'h014, 32'h0);
    bus(1'b1, 12'h020, 32'h10);
    bus(1'b1, 12'h028, 32'h10);
    bus(1'b1, 12'h000, 32'h2);
    cap();
    chk(32'(rep(0, 0, 256) + shape(0, 1'b0)), 32'h0);
    chk(32'(rep(0, 2, 0)), 32'h0);
    bus(1'b0, 12'h028, 32'h0);
    chk(rd_v, 32'h10);
    $display("user pattern done");
    bus(1'b1, 12'h000, 32'h0);
    cap();
    chk(32'(shape(0, 1'b0)), 32'h1);
    $display("stop done");
    final_report();
  end
endmodule // pattern_generator_tb
`default_nettype wire
